// >>> cpl_palette.sv
/*
  Colour palette lookup: masked pixel index into a 256 by 24 bit table,
  three stage pipeline with blank and sync alignment, byte wide host port.
  Assumes host strobes are asynchronous, active low, not both asserted,
  and that the host keeps idle gaps of several clocks between accesses.
*/
`timescale 1ns/1ps
module cpl_palette
  import cpl_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] pixel_index_in,
  input wire logic blank_n_in,
  input wire logic sync_n_in,
  input wire logic depth_8bit_in,
  input wire logic write_n_in,
  input wire logic read_n_in,
  input wire logic reg_select_lo_in,
  input wire logic reg_select_hi_in,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  output logic [7:0] red_out,
  output logic [7:0] green_out,
  output logic [7:0] blue_out,
  output logic sync_n_out
);
  typedef struct packed {
    logic [7:0] pix1;
    logic [2:0] blank_p;
    logic [2:0] sync_p;
    logic [23:0] word2;
    logic xf1;
    logic xf2;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic sync_o;
    logic [7:0] addr;
    logic [7:0] mask;
    logic [23:0] buffer;
    logic [1:0] wbyte;
    logic [1:0] rbyte;
    cpl_xfer_t xfer;
    logic [1:0] sel_w;
    logic [1:0] sel_r;
    logic [7:0] wdata;
    logic [7:0] dout;
    logic oe;
  } cpl_state_t;

  cpl_state_t st_reg;
  cpl_state_t st_next;
  logic [CPL_WW-1:0] table_mem [CPL_DEPTH];
  logic [CPL_WW-1:0] table_q;
  logic [7:0] tbl_addr;
  logic tbl_we;
  logic wr_done;
  logic rd_done;
  logic [1:0] sel_now;
  logic [7:0] data_in_used;

  assign sel_now = {reg_select_hi_in, reg_select_lo_in};

  // Host strobe completions, detected on the rising edge of each strobe.
  cpl_sync_edge u_wr_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in(write_n_in),
    .rise_out(wr_done)
  );
  cpl_sync_edge u_rd_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in(read_n_in),
    .rise_out(rd_done)
  );

  // A pending transfer borrows the table port for one pixel.
  always_comb begin
    tbl_we = (st_reg.xfer == CPL_XF_STORE);
    if (st_reg.xfer != CPL_XF_NONE) begin
      tbl_addr = st_reg.addr;
    end else begin
      tbl_addr = st_reg.pix1 & st_reg.mask;
    end
  end

  // Table storage with a registered read port.
  always_ff @(posedge clock_in) begin
    if (ce_in) begin
      if (tbl_we) begin
        table_mem[tbl_addr] <= st_reg.buffer;
      end
      table_q <= table_mem[tbl_addr];
    end
  end

  // Colour bytes keep six bits in reduced depth mode.
  assign data_in_used = depth_8bit_in ? st_reg.wdata :
    (st_reg.wdata & CPL_LOW6);

  // Next state for the pixel pipeline and the host register file.
  always_comb begin
    st_next = st_reg;
    // Stage one samples pixel, blank and sync.
    st_next.pix1 = pixel_index_in;
    st_next.blank_p = {st_reg.blank_p[1:0], blank_n_in};
    st_next.sync_p = {st_reg.sync_p[1:0], sync_n_in};
    // Stage two captures the table word; a transfer slot shows black.
    // The slot flag runs one stage per edge so it meets its own word.
    st_next.xf1 = (st_reg.xfer != CPL_XF_NONE);
    st_next.xf2 = st_reg.xf1;
    st_next.word2 = table_q;
    // Stage three splits the word into the channel fields.
    if (!st_reg.blank_p[2] || st_reg.xf2) begin
      st_next.red = '0;
      st_next.green = '0;
      st_next.blue = '0;
    end else if (depth_8bit_in) begin
      st_next.red = st_reg.word2[CPL_RED_LSB +: CPL_CW];
      st_next.green = st_reg.word2[CPL_GRN_LSB +: CPL_CW];
      st_next.blue = st_reg.word2[CPL_BLU_LSB +: CPL_CW];
    end else begin
      st_next.red = {2'h0, st_reg.word2[CPL_RED_LSB +: 6]};
      st_next.green = {2'h0, st_reg.word2[CPL_GRN_LSB +: 6]};
      st_next.blue = {2'h0, st_reg.word2[CPL_BLU_LSB +: 6]};
    end
    st_next.sync_o = st_reg.sync_p[2];

    // A load transfer fills the buffer on the same edge as the table read.
    if (st_reg.xfer == CPL_XF_LOAD) begin
      st_next.buffer = table_mem[st_reg.addr];
    end
    // Every transfer advances the address after use.
    if (st_reg.xfer != CPL_XF_NONE) begin
      st_next.addr = st_reg.addr + 8'h01;
    end
    st_next.xfer = CPL_XF_NONE;

    // Latch write select and data while the write strobe is low; latch read select once, on the first low cycle of the read strobe.
    if (!write_n_in) begin
      st_next.sel_w = sel_now;
      st_next.wdata = host_data_bus_in;
    end
    if (!read_n_in && !st_reg.oe) begin
      st_next.sel_r = sel_now;
    end
    st_next.oe = !read_n_in;

    // Read data presented while the read strobe is low.
    if (sel_now == CPL_SEL_WADDR) begin
      st_next.dout = st_reg.addr;
    end else if (sel_now == CPL_SEL_RADDR) begin
      st_next.dout = st_reg.addr;
    end else if (sel_now == CPL_SEL_MASK) begin
      st_next.dout = st_reg.mask;
    end else begin
      case (st_reg.rbyte)
        2'h0: st_next.dout = st_reg.buffer[CPL_RED_LSB +: CPL_CW];
        2'h1: st_next.dout = st_reg.buffer[CPL_GRN_LSB +: CPL_CW];
        default: st_next.dout = st_reg.buffer[CPL_BLU_LSB +: CPL_CW];
      endcase
    end

    // Completed write: act in the gap after the strobe rises.
    if (wr_done) begin
      case (st_reg.sel_w)
        CPL_SEL_WADDR: begin
          st_next.addr = st_reg.wdata;
          st_next.wbyte = CPL_BYTE_RST;
          st_next.rbyte = CPL_BYTE_RST;
        end
        CPL_SEL_RADDR: begin
          st_next.addr = st_reg.wdata;
          st_next.wbyte = CPL_BYTE_RST;
          st_next.rbyte = CPL_BYTE_RST;
          st_next.xfer = CPL_XF_LOAD;
        end
        CPL_SEL_MASK: begin
          st_next.mask = st_reg.wdata;
        end
        default: begin
          case (st_reg.wbyte)
            2'h0: st_next.buffer[CPL_RED_LSB +: CPL_CW] = data_in_used;
            2'h1: st_next.buffer[CPL_GRN_LSB +: CPL_CW] = data_in_used;
            default: st_next.buffer[CPL_BLU_LSB +: CPL_CW] = data_in_used;
          endcase
          if (st_reg.wbyte == CPL_BYTE_LAST) begin
            st_next.wbyte = CPL_BYTE_RST;
            st_next.xfer = CPL_XF_STORE;
          end else begin
            st_next.wbyte = st_reg.wbyte + 2'h1;
          end
        end
      endcase
    end else if (rd_done && st_reg.sel_r == CPL_SEL_COLOUR) begin
      // Completed colour read steps the byte pointer.
      if (st_reg.rbyte == CPL_BYTE_LAST) begin
        st_next.rbyte = CPL_BYTE_RST;
        st_next.xfer = CPL_XF_LOAD;
      end else begin
        st_next.rbyte = st_reg.rbyte + 2'h1;
      end
    end
  end

  // Register all state under reset and clock enable.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.mask <= CPL_MASK_RST;
      st_reg.addr <= CPL_ADDR_RST;
      st_reg.blank_p <= 3'h0;
      st_reg.sync_p <= 3'h0;
      st_reg.xfer <= CPL_XF_NONE;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops.
  assign red_out = st_reg.red;
  assign green_out = st_reg.green;
  assign blue_out = st_reg.blue;
  assign sync_n_out = st_reg.sync_o;
  assign host_data_bus_out = st_reg.dout;
  assign host_data_bus_oe_out = st_reg.oe;
endmodule

// >>> cpl_pkg.sv
/*
  Package for the colour palette lookup block: host port register codes,
  field positions, reset values and pipeline constants.
  Assumes a single pixel clock domain shared by all users of the package.
*/
// Operation
// - Table holds 256 entries of 24 bits, read by pixel, accessed by host.
// - Reduced depth mode uses 18 table bits, 6 bits per channel.
// - Pixel index addresses table; word splits into three channel fields.
// - Pixel, blank and sync sampled, effect appears four edges later.
// - Blank low drives zero into all channels, kept aligned to pixels.
// - Sync low passes to sync_n_out only; the three channel outputs ignore it.
// - Select 0,0 write address, 1,1 read address, 0,1 colour, 1,0 mask.
// - Host writes address then red, green, blue; blue stores and increments.
// - Writing read-mode address loads buffer from entry then increments.
// - Three buffer reads; after blue, buffer reloads and address increments.
// - Rewriting the address abandons a partial byte sequence.
// - Host accesses are asynchronous; transfers happen synchronised afterwards.
// - Pixel table address is pixel index ANDed with the mask.
// - Mask and address or colour buffer never affect one another.
// - Reduced mode keeps low six bits of each byte; full mode all eight.
// - Mask never applies to host table accesses.
// - Reading select 0,0 returns the same address as select 1,1.
// - Each buffer transfer replaces one pixel lookup cycle.
package cpl_pkg;
  localparam int CPL_DEPTH = 256;
  localparam int CPL_AW = 8;
  localparam int CPL_CW = 8;
  localparam int CPL_WW = 24;
  localparam logic [1:0] CPL_SEL_WADDR = 2'h0;
  localparam logic [1:0] CPL_SEL_COLOUR = 2'h1;
  localparam logic [1:0] CPL_SEL_MASK = 2'h2;
  localparam logic [1:0] CPL_SEL_RADDR = 2'h3;
  localparam int CPL_RED_LSB = 16;
  localparam int CPL_GRN_LSB = 8;
  localparam int CPL_BLU_LSB = 0;
  localparam logic [7:0] CPL_MASK_RST = 8'hff;
  localparam logic [7:0] CPL_ADDR_RST = 8'h00;
  localparam logic [1:0] CPL_BYTE_RST = 2'h0;
  localparam logic [1:0] CPL_BYTE_LAST = 2'h2;
  localparam logic [7:0] CPL_LOW6 = 8'h3f;
  typedef enum logic [1:0] {CPL_XF_NONE, CPL_XF_STORE, CPL_XF_LOAD}
    cpl_xfer_t;
endpackage

// >>> cpl_sync_edge.sv
/*
  Two-flop synchroniser with rising edge detector for host strobes.
  Assumes the strobe is asynchronous and held for several clock periods.
*/
`timescale 1ns/1ps
module cpl_sync_edge (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic async_in,
  output logic rise_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } cpl_sync_t;
  cpl_sync_t st_reg;
  cpl_sync_t st_next;

  // Shift the strobe through the synchroniser and an edge stage.
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  // Register the state when enabled; reset to the idle high level so that
  // no false strobe rise follows the release of reset.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_reg <= '1;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  // Rising strobe marks the end of a host access.
  assign rise_out = st_reg.s2 & ~st_reg.s3;
endmodule

// >>> cpl_palette_assertions.sv
/*
  Port checker for the palette: video pipeline and host bus timing.
  Assumes ce_in is held high while it is checked.
*/
`timescale 1ns/1ps
module cpl_palette_assertions
  import cpl_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic blank_n_in,
  input wire logic sync_n_in,
  input wire logic depth_8bit_in,
  input wire logic write_n_in,
  input wire logic read_n_in,
  input wire logic reg_select_lo_in,
  input wire logic reg_select_hi_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe_out,
  input wire logic [7:0] red_out,
  input wire logic [7:0] green_out,
  input wire logic [7:0] blue_out,
  input wire logic sync_n_out
);
  // Black pixel, six-bit headroom and read-address select decodes.
  wire black = {red_out, green_out, blue_out} == 24'h0;
  wire top2 = |{red_out[7:6], green_out[7:6], blue_out[7:6]};
  wire raddr = {reg_select_hi_in, reg_select_lo_in} == CPL_SEL_RADDR;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Sync and blank ride the pipeline; host bus follows the read strobe.
  a_sync_low: assert property (!sync_n_in |-> ##4 !sync_n_out)
    else $error("sync low not carried");
  a_sync_high: assert property (sync_n_in |-> ##4 sync_n_out)
    else $error("sync high not carried");
  a_blank_black: assert property (!blank_n_in |-> ##4 black)
    else $error("blank not black");
  a_six_bit: assert property (!depth_8bit_in [*5] |-> !top2)
    else $error("six bit overflow");
  a_oe_on: assert property (!read_n_in |=> host_data_bus_oe_out)
    else $error("bus not driven");
  a_oe_off: assert property (read_n_in |=> !host_data_bus_oe_out)
    else $error("bus still driven");
  a_read_hold: assert property (!read_n_in [*2] |=>
    $stable(host_data_bus_out)) else $error("read data moved");
  a_xfer_black: assert property ($rose(write_n_in) && $past(raddr)
    |-> ##[3:12] black) else $error("no transfer slot");
  c_blank: cover property (!blank_n_in);
  c_raddr: cover property ($rose(write_n_in) && $past(raddr));
  c_read: cover property (!read_n_in [*2]);
endmodule

bind cpl_palette cpl_palette_assertions cpl_palette_assertions_inst (
  .clock_in(clock_in), .rst_in(rst_in), .blank_n_in(blank_n_in),
  .sync_n_in(sync_n_in), .depth_8bit_in(depth_8bit_in),
  .write_n_in(write_n_in), .read_n_in(read_n_in),
  .reg_select_lo_in(reg_select_lo_in), .reg_select_hi_in(reg_select_hi_in),
  .host_data_bus_out(host_data_bus_out),
  .host_data_bus_oe_out(host_data_bus_oe_out), .red_out(red_out),
  .green_out(green_out), .blue_out(blue_out), .sync_n_out(sync_n_out));

// >>> cpl_host_model.sv
/*
  Host processor model: strobed byte accesses to the palette port.
  Assumes clock_in is the pixel clock and bus_in the resolved data bus.
*/
`timescale 1ns/1ps
module cpl_host_model (
  input wire logic clock_in,
  input wire logic [7:0] bus_in,
  output logic write_n_out,
  output logic read_n_out,
  output logic [1:0] sel_out,
  output logic [7:0] data_out
);
  // Idle bus at time zero.
  initial begin
    write_n_out = 1'h1;
    read_n_out = 1'h1;
    sel_out = 2'h0;
    data_out = 8'h00;
  end
  // Strobe held 12 clocks; released lines show the inverse afterwards.
  task automatic access(input logic is_wr, input logic [1:0] sel,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clock_in);
    #1;
    sel_out = sel;
    data_out = d;
    write_n_out = !is_wr;
    read_n_out = is_wr;
    repeat (12) @(posedge clock_in);
    q = bus_in;
    #1;
    write_n_out = 1'h1;
    read_n_out = 1'h1;
    sel_out = ~sel;
    data_out = ~d;
    repeat (8) @(posedge clock_in);
    #1;
  endtask
endmodule

// >>> test_colour_palette_lookup.sv
/*
  Testbench for the palette: host model drives the port, the bench drives
  pixels and judges registers, table contents and channel outputs.
  Assumes the checker and host model files are compiled before it.
*/
`timescale 1ns/1ps
module test_colour_palette_lookup import cpl_pkg::*;;
  logic clock_in = 1'h0;
  logic rst_in = 1'h1;
  logic [7:0] pix = 8'h00;
  logic blank_n = 1'h1;
  logic sync_n = 1'h1;
  logic depth8 = 1'h1;
  logic wr_n, rd_n, oe, sync_o;
  logic [1:0] sel;
  logic [7:0] hdata, dout, bus, red, grn, blu, q;
  logic [7:0] v [6] = '{8'h12, 8'h34, 8'h56, 8'h0a, 8'h0b, 8'h0c};
  int num_errors = 0;
  int total_checks = 0;
  // Resolved data bus: the palette wins while it drives.
  assign bus = oe ? dout : hdata;
  always #2.5 clock_in = ~clock_in;
  cpl_host_model cpl_host_model_inst (.clock_in(clock_in), .bus_in(bus),
    .write_n_out(wr_n), .read_n_out(rd_n), .sel_out(sel), .data_out(hdata));
  cpl_palette cpl_palette_inst (.clock_in(clock_in), .rst_in(rst_in),
    .ce_in(1'h1), .pixel_index_in(pix), .blank_n_in(blank_n),
    .sync_n_in(sync_n), .depth_8bit_in(depth8), .write_n_in(wr_n),
    .read_n_in(rd_n), .reg_select_lo_in(sel[0]), .reg_select_hi_in(sel[1]),
    .host_data_bus_in(bus), .host_data_bus_out(dout),
    .host_data_bus_oe_out(oe), .red_out(red), .green_out(grn),
    .blue_out(blu), .sync_n_out(sync_o));
  // Compares one value and counts it.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Host write, and host read with comparison.
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    cpl_host_model_inst.access(1'h1, s, d, q);
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    cpl_host_model_inst.access(1'h0, s, 8'h00, q);
    chk({16'h0, q}, {16'h0, e});
  endtask
  // Shows one pixel and checks the channels once it has crossed the pipe.
  task automatic px(input logic [7:0] i, input logic [23:0] e);
    @(posedge clock_in);
    #1;
    pix = i;
    repeat (4) @(posedge clock_in);
    #1;
    chk({red, grn, blu}, e);
  endtask
  // Reset values, one address behind two codes, mask kept apart.
  task automatic t_regs();
    rd(CPL_SEL_MASK, CPL_MASK_RST);
    rd(CPL_SEL_RADDR, CPL_ADDR_RST);
    wr(CPL_SEL_WADDR, 8'h05);
    rd(CPL_SEL_WADDR, 8'h05);
    rd(CPL_SEL_RADDR, 8'h05);
    wr(CPL_SEL_MASK, 8'h0f);
    rd(CPL_SEL_MASK, 8'h0f);
    rd(CPL_SEL_WADDR, 8'h05);
  endtask
  // Abandoned sequence, wrap past 255, write then read back in turn.
  task automatic t_table();
    wr(CPL_SEL_WADDR, 8'hff);
    wr(CPL_SEL_COLOUR, 8'h77);
    wr(CPL_SEL_WADDR, 8'hff);
    foreach (v[k]) wr(CPL_SEL_COLOUR, v[k]);
    rd(CPL_SEL_WADDR, 8'h01);
    wr(CPL_SEL_RADDR, 8'hff);
    rd(CPL_SEL_WADDR, 8'h00);
    foreach (v[k]) rd(CPL_SEL_COLOUR, v[k]);
    rd(CPL_SEL_WADDR, 8'h02);
  endtask
  // Masked index, full index, then blank and sync low together.
  task automatic t_pixel();
    px(8'hf0, 24'h0a0b0c);
    wr(CPL_SEL_MASK, 8'hff);
    px(8'hff, 24'h123456);
    blank_n = 1'h0;
    sync_n = 1'h0;
    px(8'hff, 24'h0);
    chk({23'h0, sync_o}, 24'h0);
    blank_n = 1'h1;
    sync_n = 1'h1;
  endtask
  // Six-bit mode keeps the low six bits of each byte.
  task automatic t_six();
    depth8 = 1'h0;
    wr(CPL_SEL_WADDR, 8'h40);
    repeat (3) wr(CPL_SEL_COLOUR, 8'hff);
    wr(CPL_SEL_RADDR, 8'h40);
    rd(CPL_SEL_COLOUR, 8'h3f);
    px(8'h40, 24'h3f3f3f);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence after a 12 cycle reset.
  initial begin
    repeat (12) @(posedge clock_in);
    #1;
    rst_in = 1'h0;
    t_regs();
    t_table();
    t_pixel();
    t_six();
    summarize();
  end
  // Watchdog: the run needs about 750 clocks.
  initial begin
    #50000;
    num_errors++;
    summarize();
  end
endmodule
